// ---- rtl/pwr_seq_pkg.sv ----
// constants, states and carriers for the power-fail shutdown sequencer
package pwr_seq_pkg;

	localparam int CLK_MHZ = 100;
	localparam int AC_OUTAGE_MS = 20;
	localparam int RESUME_RETRACT_MS = 200;
	localparam int AC_OUTAGE_CYC = AC_OUTAGE_MS * 1000 * CLK_MHZ;
	localparam int RESUME_RETRACT_CYC = RESUME_RETRACT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_INHIBIT = 3'b001,
		ST_WBLOCK = 3'b011,
		ST_RETRACT = 3'b010,
		ST_OFF = 3'b110,
		ST_RES_BLOCK = 3'b111,
		ST_RES_WAIT = 3'b101
	} seq_state_e;

	typedef struct packed {
		logic over_voltage;
		logic under_voltage;
		logic over_current;
	} dc_fault_s;

	typedef struct packed {
		logic command_inhibit;
		logic supply_fault_write_block;
		logic head_retract_n;
		logic power_enable;
	} seq_out_s;

	localparam seq_out_s OUT_RESET = '{1'b1, 1'b1, 1'b0, 1'b0};

endpackage

// ---- rtl/power_fail_shutdown_sequencer.sv ----
// power-fail shutdown and resumption sequencer for a drive regulator board
`timescale 1ns/1ps
// Functional notes
// R1 - an ac failure is declared only after input power has been absent for 20 ms.
// R2 - shutdown asserts command inhibit, then write block, then head retract, then power off.
// R3 - under command inhibit a sector write in progress finishes and pending writes are dropped.
// R4 - under the supply-fault write block no write reaches the disk.
// R5 - driving head_retract_n low unloads the heads during shutdown.
// R6 - on ac return the write block is asserted before any other resumption step.
// R7 - on resumption heads stay retracted for 200 ms before power is switched on.
// R8 - dc over-voltage, under-voltage or over-current triggers a dc shutdown.
// R9 - a dc shutdown runs the same sequence at once, without the outage wait.
// R10 - after a dc shutdown power stays off until the fault clears and main reset is applied.
// R11 - power returning before the outage interval elapses restarts the timer, no action.
module power_fail_shutdown_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int OUTAGE_CYC = AC_OUTAGE_CYC,
	parameter int RETRACT_CYC = RESUME_RETRACT_CYC
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ac_ok,
	input wire dc_fault_s dc_fault,
	input wire logic main_reset,
	input wire logic sector_write_busy,
	input wire logic write_request,
	output logic command_inhibit,
	output logic supply_fault_write_block,
	output logic head_retract_n,
	output logic power_enable,
	output logic write_enable,
	output logic write_accept,
	output logic dc_latched
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic [6:0] sync1_nxt;

	always_comb
	begin
		sync1_nxt = {write_request, ac_ok, dc_fault, main_reset, sector_write_busy};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end
		else
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync1_r;
		end
	end

	logic ac_s;
	logic dc_any_s;
	logic mreset_s;
	logic busy_s;
	logic wreq_s;

	always_comb
	begin
		ac_s = sync2_r[5];
		// R8 three dc causes
		dc_any_s = |sync2_r[4:2];
		mreset_s = sync2_r[1];
		busy_s = sync2_r[0];
		wreq_s = sync2_r[6];
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	seq_state_e state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic dc_lat_r, dc_lat_nxt;
	seq_out_s out_r, out_nxt;
	logic wen_r, wen_nxt;
	logic wacc_r, wacc_nxt;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		dc_lat_nxt = dc_lat_r;
		out_nxt = out_r;
		unique case (state_r)
			ST_RUN:
			begin
				out_nxt = '{1'b0, 1'b0, 1'b1, 1'b1};
				if (dc_any_s)
				begin
					// R9 dc skips wait
					dc_lat_nxt = 1'b1;
					cnt_nxt = '0;
					state_nxt = ST_INHIBIT;
				end
				else if (ac_s)
				begin
					// R11 glitch restarts timer
					cnt_nxt = '0;
				end
				else if (cnt_r >= CNT_W'(OUTAGE_CYC - 1))
				begin
					// R1 outage timed out
					cnt_nxt = '0;
					state_nxt = ST_INHIBIT;
				end
				else
				begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			ST_INHIBIT:
			begin
				// R2 inhibit first
				out_nxt.command_inhibit = 1'b1;
				state_nxt = ST_WBLOCK;
			end
			ST_WBLOCK:
			begin
				// R3 let sector write finish
				if (!busy_s)
				begin
					out_nxt.supply_fault_write_block = 1'b1;
					state_nxt = ST_RETRACT;
				end
			end
			ST_RETRACT:
			begin
				// R5 unload heads
				out_nxt.head_retract_n = 1'b0;
				state_nxt = ST_OFF;
			end
			ST_OFF:
			begin
				// R2 power off last
				out_nxt.power_enable = 1'b0;
				if (dc_lat_r)
				begin
					// R10 needs cleared fault and main reset
					if (!dc_any_s && mreset_s)
					begin
						dc_lat_nxt = 1'b0;
					end
				end
				else if (ac_s && !dc_any_s)
				begin
					state_nxt = ST_RES_BLOCK;
				end
			end
			ST_RES_BLOCK:
			begin
				// R6 write block before anything else
				out_nxt.supply_fault_write_block = 1'b1;
				out_nxt.head_retract_n = 1'b0;
				cnt_nxt = '0;
				state_nxt = ST_RES_WAIT;
			end
			ST_RES_WAIT:
			begin
				if (dc_any_s || !ac_s)
				begin
					// lost again: go back to the safe off state
					dc_lat_nxt = dc_any_s;
					state_nxt = ST_OFF;
				end
				else if (cnt_r >= CNT_W'(RETRACT_CYC - 1))
				begin
					// R7 power on after retract hold
					cnt_nxt = '0;
					out_nxt = '{1'b0, 1'b0, 1'b1, 1'b1};
					state_nxt = ST_RUN;
				end
				else
				begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			default:
			begin
				state_nxt = ST_OFF;
			end
		endcase
		// R4 no write while blocked or powered off
		wen_nxt = !out_nxt.supply_fault_write_block && out_nxt.power_enable;
		// R3 pending writes discarded under inhibit
		wacc_nxt = wreq_s && !out_nxt.command_inhibit && wen_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_RES_BLOCK;
			cnt_r <= '0;
			dc_lat_r <= 1'b0;
			out_r <= OUT_RESET;
			wen_r <= 1'b0;
			wacc_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			dc_lat_r <= dc_lat_nxt;
			out_r <= out_nxt;
			wen_r <= wen_nxt;
			wacc_r <= wacc_nxt;
		end
	end

	assign command_inhibit = out_r.command_inhibit;
	assign supply_fault_write_block = out_r.supply_fault_write_block;
	assign head_retract_n = out_r.head_retract_n;
	assign power_enable = out_r.power_enable;
	assign write_enable = wen_r;
	assign write_accept = wacc_r;
	assign dc_latched = dc_lat_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_power_off_safe: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!power_enable |-> !head_retract_n && supply_fault_write_block) // R2
		else $error("power off without retract and write block");

	a_retract_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(head_retract_n) && state_r == ST_OFF |-> $past(supply_fault_write_block)) // R5
		else $error("retract before write block");

	a_block_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		supply_fault_write_block |-> !write_enable && !write_accept) // R4
		else $error("write allowed while blocked");

	a_inhibit_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
		command_inhibit |-> !write_accept) // R3
		else $error("write accepted under inhibit");

	a_dc_immediate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_RUN && dc_any_s |=> state_r == ST_INHIBIT ##1 command_inhibit) // R9
		else $error("dc shutdown delayed");

	a_dc_latched_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dc_lat_r && !power_enable |=> !power_enable) // R10
		else $error("power on with dc latch");

	a_resume_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_RES_BLOCK |=> supply_fault_write_block && !head_retract_n) // R6
		else $error("resume without write block");

	a_resume_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(power_enable) |-> $past(state_r) == ST_RES_WAIT
			&& $past(cnt_r) >= CNT_W'(RETRACT_CYC - 1)) // R7
		else $error("power on before retract hold");

	a_outage_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_RUN && ac_s && !dc_any_s |=> state_r == ST_RUN) // R11
		else $error("shutdown with ac present");

	a_outage_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_RUN && $past(state_r) == ST_RUN && !$past(dc_any_s)
			&& !ac_s && cnt_r < CNT_W'(OUTAGE_CYC - 1) && !dc_any_s |=> state_r == ST_RUN) // R1
		else $error("ac failure declared early");

	a_dc_causes: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == ST_RUN && |sync2_r[4:2] |=> dc_lat_r) // R8
		else $error("dc cause missed");

endmodule

// ---- sim/write_path_model.sv ----
// far-side model: sector write timing and pending write commands
`timescale 1ns/1ps
module write_path_model #(
	parameter int BUSY_CYC = 40
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start_write,
	input wire logic want_write,
	output logic sector_write_busy,
	output logic write_request
);
	logic go_d_r;
	int cnt_r;

	// a begun sector write runs to its end whatever the sequencer does
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			go_d_r <= 1'b0;
			cnt_r <= 0;
		end
		else
		begin
			go_d_r <= start_write;
			if (start_write && !go_d_r)
				cnt_r <= BUSY_CYC;
			else if (cnt_r > 0)
				cnt_r <= cnt_r - 1;
		end
	end
	assign sector_write_busy = cnt_r > 0;
	assign write_request = want_write;
endmodule

// ---- sim/tb_power_fail_shutdown_sequencer.sv ----
// self-checking bench for the power-fail shutdown sequencer
`timescale 1ns/1ps
module tb_power_fail_shutdown_sequencer
	import pwr_seq_pkg::*;
;
	// short counts keep the run brief
	localparam int OC = 20;
	localparam int RC = 50;
	logic sys_clk = 1'b0;
	logic rst_n, ac_ok, main_reset, go, want;
	dc_fault_s dc_fault;
	logic command_inhibit, supply_fault_write_block, head_retract_n, power_enable;
	logic write_enable, write_accept, dc_latched, sector_write_busy, write_request;
	logic [3:0] ov;
	int n_errors = 0;
	int checks = 0;
	int n;

	assign ov = {command_inhibit, supply_fault_write_block, head_retract_n, power_enable};
	always #5 sys_clk = ~sys_clk;

	power_fail_shutdown_sequencer #(.OUTAGE_CYC(OC), .RETRACT_CYC(RC)) uut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ac_ok(ac_ok),
		.dc_fault(dc_fault),
		.main_reset(main_reset),
		.sector_write_busy(sector_write_busy),
		.write_request(write_request),
		.command_inhibit(command_inhibit),
		.supply_fault_write_block(supply_fault_write_block),
		.head_retract_n(head_retract_n),
		.power_enable(power_enable),
		.write_enable(write_enable),
		.write_accept(write_accept),
		.dc_latched(dc_latched)
	);

	write_path_model wpm (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start_write(go),
		.want_write(want),
		.sector_write_busy(sector_write_busy),
		.write_request(write_request)
	);

	// ----------------
	// helpers
	// ----------------
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_ov(input logic [3:0] exp, input int lim);
		n = 0;
		#1;
		while (ov !== exp && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask

	task automatic results();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------
	// scenarios
	// ----------------
	task automatic t_resume(input string s);
		cyc(3);
		chk(ov, 4'b1100);
		chk({3'h0, write_enable}, 4'h0);
		wait_ov(4'b0011, RC + 10);
		chk({3'h0, n >= RC - 3}, 4'h1);
		chk(ov, 4'b0011);
		chk({3'h0, write_enable}, 4'h1);
		$display("test resume %s done", s);
	endtask

	task automatic t_short();
		@(posedge sys_clk) ac_ok <= 1'b0;
		cyc(OC - 4);
		@(posedge sys_clk) ac_ok <= 1'b1;
		cyc(3);
		@(posedge sys_clk) ac_ok <= 1'b0;
		cyc(OC - 4);
		@(posedge sys_clk) ac_ok <= 1'b1;
		cyc(8);
		chk(ov, 4'b0011);
		$display("test short outage done");
	endtask

	// ac lost again during the retract hold must not power up
	task automatic t_lost();
		@(posedge sys_clk) ac_ok <= 1'b0;
		wait_ov(4'b1100, OC + 20);
		chk(ov, 4'b1100);
		@(posedge sys_clk) ac_ok <= 1'b1;
		cyc(10);
		@(posedge sys_clk) ac_ok <= 1'b0;
		cyc(RC + 10);
		chk(ov, 4'b1100);
		@(posedge sys_clk) ac_ok <= 1'b1;
		t_resume("lost");
	endtask

	task automatic t_ac();
		@(posedge sys_clk) want <= 1'b1;
		cyc(4);
		chk({3'h0, write_accept}, 4'h1);
		@(posedge sys_clk);
		ac_ok <= 1'b0;
		go <= 1'b1;
		wait_ov(4'b1011, OC + 10);
		chk({3'h0, n >= OC}, 4'h1);
		cyc(3);
		chk({3'h0, write_accept}, 4'h0);
		chk(ov, 4'b1011);
		wait_ov(4'b1111, 40);
		chk({3'h0, sector_write_busy}, 4'h0);
		chk({3'h0, write_enable}, 4'h0);
		cyc(1);
		chk(ov, 4'b1101);
		cyc(1);
		chk(ov, 4'b1100);
		@(posedge sys_clk);
		go <= 1'b0;
		want <= 1'b0;
		ac_ok <= 1'b1;
		t_resume("ac");
	endtask

	task automatic t_dc();
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk) dc_fault <= dc_fault_s'(3'b100 >> i);
			wait_ov(4'b1011, 8);
			chk({3'h0, n <= 5}, 4'h1);
			chk({3'h0, dc_latched}, 4'h1);
			cyc(3);
			chk(ov, 4'b1100);
			@(posedge sys_clk) main_reset <= 1'b1;
			cyc(4);
			@(posedge sys_clk) main_reset <= 1'b0;
			@(posedge sys_clk) dc_fault <= '0;
			cyc(RC + 10);
			chk(ov, 4'b1100);
			chk({3'h0, dc_latched}, 4'h1);
			@(posedge sys_clk) main_reset <= 1'b1;
			cyc(3);
			@(posedge sys_clk) main_reset <= 1'b0;
			t_resume("dc");
			chk({3'h0, dc_latched}, 4'h0);
		end
		$display("test dc shutdown done");
	endtask

	initial
	begin
		rst_n <= 1'b0;
		ac_ok <= 1'b1;
		dc_fault <= '0;
		main_reset <= 1'b0;
		go <= 1'b0;
		want <= 1'b0;
		cyc(5);
		chk(ov, 4'b1100);
		@(posedge sys_clk) rst_n <= 1'b1;
		t_resume("reset");
		t_short();
		t_lost();
		t_ac();
		t_dc();
		results();
	end

	// about five times the expected run
	initial
	begin
		cyc(4000);
		n_errors++;
		results();
	end
endmodule
